// file: dv/lpm_core_model.sv
// processor core stand-in: issues power-down requests, runs a program counter
// assumes the controller's clock enable and run outputs gate it
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic sys_clk_en_i,
	input wire logic cpu_run_i,
	input wire logic [1:0] op_i,
	output logic stop_req_o,
	output logic halt_req_o,
	output logic [15:0] pc_o
);
	logic go;
	assign go = sys_clk_en_i & cpu_run_i;
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pc_o <= 16'h0000;
			stop_req_o <= 1'b0;
			halt_req_o <= 1'b0;
		end else begin
			pc_o <= pc_o + 16'(go);
			stop_req_o <= go & op_i[0];
			halt_req_o <= go & op_i[1];
		end
	end
endmodule // lpm_core_model
`default_nettype wire

// file: dv/lpm_ctrl_tb.sv
// self-checking bench for the low-power mode controller
// assumes one apb wait state and a 100 cycle oscillator settle
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_tb;
	logic clock_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0, wake_i = 0, irq_i = 0, bod_stop_opt_i = 0;
	logic [11:0] paddr = 0, st;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err, stop_req, halt_req, sys_clk_en_o, cpu_run_o, pc_hold_o, xtal_osc_en_o, ipo_en_o;
	logic xtal_pins_en_o, wdt_osc_en_o, wdt_run_o, bod_en_o, amp_en_o;
	logic [1:0] op = 0, port_out_i = 2'b10, port_oe_n_i = 2'b01, lpm_state_o, p_out, p_oe_n;
	logic [7:0] periph_en_i = 8'h5a, periph_run_o;
	logic [15:0] pc, pc0;
	int miscompares = 0, check_count = 0, n;
	assign st = {lpm_state_o, sys_clk_en_o, cpu_run_o, pc_hold_o, xtal_osc_en_o, ipo_en_o, xtal_pins_en_o,
		wdt_osc_en_o, wdt_run_o, bod_en_o, amp_en_o};
	always #5 clock_i = ~clock_i;
	lpm_core_model core_u (.clock_i, .reset_n_i, .sys_clk_en_i(sys_clk_en_o), .cpu_run_i(cpu_run_o), .op_i(op),
		.stop_req_o(stop_req), .halt_req_o(halt_req), .pc_o(pc));
	lpm_ctrl dut_u (.clock_i, .reset_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.stop_req_i(stop_req), .halt_req_i(halt_req), .wake_i, .irq_i, .bod_stop_opt_i, .port_out_i, .port_oe_n_i,
		.periph_en_i, .lpm_state_o, .sys_clk_en_o, .cpu_run_o, .pc_hold_o, .xtal_osc_en_o, .ipo_en_o, .xtal_pins_en_o,
		.crystal_shared_port_pins_out_o(p_out), .crystal_shared_port_pins_oe_n_o(p_oe_n), .wdt_osc_en_o,
		.wdt_run_o, .bod_en_o, .amp_en_o, .periph_run_o);
	// ==========
	// tasks
	task automatic end_sim();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clock_i);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock_i);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clock_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			miscompares++;
			end_sim();
		end
		rd = prdata; err = pslverr; psel <= 0; penable <= 0;
	endtask
	task automatic wait_st(input logic [1:0] s);
		n = 0;
		while (lpm_state_o !== s && n < 300) begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 300) begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic core(input logic [1:0] o);
		@(posedge clock_i); op <= o;
		@(posedge clock_i); op <= 0;
	endtask
	task automatic t_regs();
		chk(st, 12'h320);
		apb(1, 12'h000, 32'h1f); apb(0, 12'h000, 0); chk(rd, 32'h1f);
		apb(1, 12'h004, 1); chk(err, 1); apb(0, 12'h00c, 0); chk(err, 1);
		apb(0, 12'h004, 0); chk(rd, 0); chk(err, 0);
		repeat (2) @(posedge clock_i);
		chk(st, 12'h37f); chk(periph_run_o, 8'h5a);
	endtask
	task automatic t_stop();
		core(2'b01); wait_st(2);
		chk(st, 12'h88d);
		chk({p_oe_n, p_out}, 4'b0110); chk(periph_run_o, 0);
		pc0 = pc;
		@(posedge clock_i); irq_i <= 1; @(posedge clock_i); irq_i <= 0;
		repeat (5) @(posedge clock_i);
		chk(lpm_state_o, 2); chk(pc, pc0);
		bod_stop_opt_i <= 1; repeat (3) @(posedge clock_i); chk(bod_en_o, 1);
		apb(1, 12'h000, 0); repeat (2) @(posedge clock_i); chk(st, 12'h880);
		@(posedge clock_i); wake_i <= 1; @(posedge clock_i); wake_i <= 0;
		wait_st(3); chk(sys_clk_en_o, 0); chk(ipo_en_o, 1);
		wait_st(0); chk(32'(n >= 97 && n <= 103), 1); chk(st, 12'h320);
		core(2'b01); wait_st(2); apb(1, 12'h008, 1); wait_st(0); chk(st, 12'h320);
	endtask
	task automatic t_halt();
		core(2'b10); wait_st(1); chk(st, 12'h6a0); chk(periph_run_o, 8'h5a);
		@(posedge clock_i); irq_i <= 1; @(posedge clock_i); irq_i <= 0;
		wait_st(0); chk(st, 12'h320);
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		reset_n_i <= 1;
		@(posedge clock_i);
		t_regs();
		t_stop();
		t_halt();
		end_sim();
	end
endmodule // lpm_ctrl_tb
`default_nettype wire

// file: pkg/lpm_cfg.svh
// constants for the low-power mode controller
// assumes a 100 MHz system clock and an APB register port
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
`define LPM_ADDR_CTRL 12'h000
`define LPM_ADDR_STAT 12'h004
`define LPM_ADDR_CMD 12'h008
`define LPM_CTRL_RST 8'h00
`define LPM_BIT_WDT_EN 0
`define LPM_BIT_WDT_OSC 1
`define LPM_BIT_BOD_EN 2
`define LPM_BIT_AMP_EN 3
`define LPM_BIT_XTAL_EN 4
`define LPM_CMD_RECOVER 0
`define LPM_OSC_SETTLE_NS 1000
`define LPM_CLK_NS 10
`define LPM_OSC_SETTLE_CYC ((`LPM_OSC_SETTLE_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`define LPM_CNT_W 8
`endif

// file: pkg/lpm_pkg.sv
// types for the low-power mode controller
// assumes lpm_cfg.svh on the include path
package lpm_pkg;
	typedef enum logic [1:0] {LPM_ACTIVE, LPM_HALT, LPM_STOP, LPM_WAKE} lpm_state_t;
endpackage

// file: pkg/lpm_settle_if.sv
// settle counter handshake between controller and timer
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface lpm_settle_if;
	logic start;
	logic done;
	modport ctrl (output start, input done);
	modport tmr (input start, output done);
endinterface
`default_nettype wire

// file: verilog/lpm_ctrl.sv
// low-power mode controller: active, halt, stop, wake
// assumes the core pulses stop/halt requests and a recovery source pulses wake
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_ctrl (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic stop_req_i,
	input wire logic halt_req_i,
	input wire logic wake_i,
	input wire logic irq_i,
	input wire logic bod_stop_opt_i,
	input wire logic [1:0] port_out_i,
	input wire logic [1:0] port_oe_n_i,
	input wire logic [7:0] periph_en_i,
	output logic [1:0] lpm_state_o,
	output logic sys_clk_en_o,
	output logic cpu_run_o,
	output logic pc_hold_o,
	output logic xtal_osc_en_o,
	output logic ipo_en_o,
	output logic xtal_pins_en_o,
	output logic [1:0] crystal_shared_port_pins_out_o,
	output logic [1:0] crystal_shared_port_pins_oe_n_o,
	output logic wdt_osc_en_o,
	output logic wdt_run_o,
	output logic bod_en_o,
	output logic amp_en_o,
	output logic [7:0] periph_run_o
);
	import lpm_pkg::*;
	// ==================================================
	// registers and apb
	lpm_state_t st_q, st_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic recover_q, recover_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d, err_q, err_d;
	lpm_settle_if sif ();
	lpm_settle_timer u_settle (.clock_i(clock_i), .reset_n_i(reset_n_i), .sif(sif));
	logic acc;
	assign acc = psel && penable && !ready_q;
	always_comb begin
		ctrl_d = ctrl_q;
		recover_d = 1'b0;
		rdata_d = rdata_q;
		ready_d = acc;
		err_d = 1'b0;
		if (acc) begin
			rdata_d = '0;
			case (paddr)
				`LPM_ADDR_CTRL: begin
					if (pwrite)
						ctrl_d = pwdata[7:0];
					else
						rdata_d = {24'h000000, ctrl_q};
				end
				`LPM_ADDR_STAT: begin
					if (pwrite)
						err_d = 1'b1;
					else
						rdata_d = {30'h00000000, st_q};
				end
				`LPM_ADDR_CMD: begin
					if (pwrite)
						recover_d = pwdata[`LPM_CMD_RECOVER];
				end
				default: err_d = 1'b1;
			endcase
		end
	end
	// ==================================================
	// mode state machine
	logic in_stop_d;
	logic [1:0] xpins_d, xoe_d;
	always_comb begin
		st_d = st_q;
		sif.start = 1'b0;
		case (st_q)
			LPM_ACTIVE: begin
				if (stop_req_i)
					st_d = LPM_STOP;
				else if (halt_req_i)
					st_d = LPM_HALT;
			end
			LPM_HALT: begin
				if (irq_i || wake_i)
					st_d = LPM_ACTIVE;
			end
			LPM_STOP: begin
				if (wake_i || recover_q) begin
					st_d = LPM_WAKE;
					sif.start = 1'b1;
				end
			end
			LPM_WAKE: begin
				if (sif.done)
					st_d = LPM_ACTIVE;
			end
			default: st_d = LPM_ACTIVE;
		endcase
	end
	assign in_stop_d = (st_d == LPM_STOP) || (st_d == LPM_WAKE);
	// ==================================================
	// output registers
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= LPM_ACTIVE;
			ctrl_q <= `LPM_CTRL_RST;
			recover_q <= 1'b0;
			rdata_q <= '0;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			lpm_state_o <= 2'h0;
			sys_clk_en_o <= 1'b1;
			cpu_run_o <= 1'b1;
			pc_hold_o <= 1'b0;
			xtal_osc_en_o <= 1'b0;
			ipo_en_o <= 1'b1;
			xtal_pins_en_o <= 1'b0;
			crystal_shared_port_pins_out_o <= 2'h0;
			crystal_shared_port_pins_oe_n_o <= 2'h3;
			wdt_osc_en_o <= 1'b0;
			wdt_run_o <= 1'b0;
			bod_en_o <= 1'b0;
			amp_en_o <= 1'b0;
			periph_run_o <= 8'h00;
		end else begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			recover_q <= recover_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
			lpm_state_o <= st_d;
			sys_clk_en_o <= !in_stop_d;
			cpu_run_o <= (st_d == LPM_ACTIVE);
			pc_hold_o <= (st_d != LPM_ACTIVE);
			xtal_osc_en_o <= (st_d != LPM_STOP) && ctrl_d[`LPM_BIT_XTAL_EN];
			ipo_en_o <= (st_d != LPM_STOP);
			xtal_pins_en_o <= !in_stop_d && ctrl_d[`LPM_BIT_XTAL_EN];
			crystal_shared_port_pins_out_o <= port_out_i;
			crystal_shared_port_pins_oe_n_o <= (!in_stop_d && ctrl_d[`LPM_BIT_XTAL_EN]) ? 2'h3 : port_oe_n_i;
			wdt_osc_en_o <= ctrl_d[`LPM_BIT_WDT_OSC];
			wdt_run_o <= ctrl_d[`LPM_BIT_WDT_EN] && ctrl_d[`LPM_BIT_WDT_OSC];
			bod_en_o <= ctrl_d[`LPM_BIT_BOD_EN] && (!in_stop_d || bod_stop_opt_i);
			amp_en_o <= ctrl_d[`LPM_BIT_AMP_EN];
			periph_run_o <= in_stop_d ? 8'h00 : periph_en_i;
		end
	end
	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;
	// ==================================================
	// checks
	stop_clk_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP) |-> !sys_clk_en_o) else $error("clock running in stop");
	stop_osc_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP) |-> (!xtal_osc_en_o && !ipo_en_o && !xtal_pins_en_o)) else $error("osc on in stop");
	stop_cpu_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q != LPM_ACTIVE) |-> (!cpu_run_o && pc_hold_o)) else $error("cpu running while low power");
	halt_clk_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_HALT) |-> sys_clk_en_o) else $error("halt gated clock");
	stop_enter_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_ACTIVE && stop_req_i) |=> (st_q == LPM_STOP)) else $error("stop not entered");
	stop_exit_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP && !wake_i && !recover_q) |=> (st_q == LPM_STOP)) else $error("stop left early");
	wake_settle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP) ##1 (st_q == LPM_WAKE) |-> (st_q == LPM_WAKE)[*8]) else $error("clock released early");
	periph_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP) |-> (periph_run_o == 8'h00)) else $error("peripheral active in stop");
	bod_opt_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP && !bod_stop_opt_i && !$past(bod_stop_opt_i)) |-> !bod_en_o) else $error("bod on in stop");
	wdt_osc_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP) |-> (wdt_osc_en_o == ctrl_q[`LPM_BIT_WDT_OSC])) else $error("wdt osc wrong in stop");
	wdt_run_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP) |-> (wdt_run_o == (ctrl_q[`LPM_BIT_WDT_EN] && ctrl_q[`LPM_BIT_WDT_OSC])))
		else $error("wdt logic wrong in stop");
	amp_stop_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP) |-> (amp_en_o == ctrl_q[`LPM_BIT_AMP_EN])) else $error("amp wrong in stop");
	stop_pins_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(st_q == LPM_STOP && $past(st_q) == LPM_STOP) |-> (crystal_shared_port_pins_oe_n_o == $past(port_oe_n_i)))
		else $error("shared pins not from port settings");
endmodule // lpm_ctrl
`default_nettype wire

// file: verilog/lpm_settle_timer.sv
// oscillator settle timer, counts from a start pulse
// assumes one free-running clock
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_settle_timer (
	input wire logic clock_i,
	input wire logic reset_n_i,
	lpm_settle_if.tmr sif
);
	import lpm_pkg::*;
	localparam int CNT_W = `LPM_CNT_W;
	// settle count in cycles, cast to the counter width; 100 fits in 8 bits, so nothing is cut
	localparam logic [`LPM_CNT_W-1:0] SETTLE = CNT_W'(`LPM_OSC_SETTLE_CYC);
	logic [`LPM_CNT_W-1:0] cnt_q, cnt_d;
	logic run_q, run_d;
	logic done_q, done_d;
	assign sif.done = done_q;
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = 1'b0;
		if (sif.start) begin
			cnt_d = '0;
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q == SETTLE - 1'b1) begin
				run_d = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end
endmodule // lpm_settle_timer
`default_nettype wire
